// >>> rtl/jst_params.svh
// Purpose: constants for the serial transmitter: register offsets, fields, resets, control codes
// Assumes: included by bare name from the transmitter top and the testbench
// Notes:   link parameter fields hold value minus one where the value is never zero
`ifndef JST_PARAMS_SVH
`define JST_PARAMS_SVH
// ==========================================================
// register offsets
`define JST_ADDR_TPAT    8'hC0
`define JST_ADDR_LINK    8'h70
`define JST_ADDR_KM1     8'h71
`define JST_ADDR_STAT    8'h72
// ==========================================================
// link and test pattern register fields and reset values
`define JST_LINK_SIMPLE  0
`define JST_LINK_TWO     1
`define JST_LINK_SCR     2
`define JST_LINK_LSYNC   3
`define JST_LINK_RST     8'h08
`define JST_KM1_RST      5'h08
`define JST_TPAT_RST     8'h00
`define JST_TPAT_EN      7
// ==========================================================
// control characters and fixed patterns
`define JST_K_COMMA      8'hBC
`define JST_K_R          8'h1C
`define JST_K_A          8'h7C
`define JST_K_Q          8'h9C
`define JST_K_F          8'hFC
`define JST_D_CONST      8'hB5
`define JST_ALT_A        14'h2AAA
`define JST_ALT_B        14'h1555
`define JST_PRBS_SEED    7'h7F
// ==========================================================
// sequence lengths and encoded link parameters
`define JST_ILA_MF       10'h004
`define JST_ILA_MF_LAST  2'h3
`define JST_CFG_FIRST    8'h02
`define JST_CFG_LAST     8'h0F
`define JST_F_EFF_M1     3'h6
`define JST_F_SIM_M1     3'h1
`define JST_S3_M1        3'h5
`define JST_S2_M1        3'h3
`define JST_SS_M1        3'h0
`define JST_M_M1         8'h01
`define JST_N_M1         5'h0D
`define JST_NP_SIM_M1    5'h0F
`define JST_SUBCV        3'h2
`define JST_JESDV        3'h1
// identity octets: arbitrary values
`define JST_DEV_ID       8'h5A
`define JST_BANK_ID      8'h03
`endif

// >>> rtl/jst_pkg.sv
// Purpose: shared types for the serial transmitter
// Assumes: nothing
// Notes:   states are one-hot
package jst_pkg;
	typedef enum logic [2:0] {
		JST_CGS  = 3'b001,
		JST_ILA  = 3'b010,
		JST_DATA = 3'b100
	} jst_state_t;
	typedef enum logic [2:0] {
		JST_TP_RAMP  = 3'h1,
		JST_TP_ALT   = 3'h2,
		JST_TP_PRBS  = 3'h4,
		JST_TP_CONST = 3'h5
	} jst_tpat_t;
endpackage : jst_pkg

// >>> rtl/jst_pair_buf.sv
// Purpose: two-entry buffer between the sample source and the frame packer
// Assumes: both sides on ref_clk
// Notes:   in_ready comes from a flop
`timescale 1ns/10ps
module jst_pair_buf (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [27:0] in_data,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic [27:0]      out_data
);
	logic [27:0] mem_reg [0:1];
	logic        wr_ptr_reg;
	logic        rd_ptr_reg;
	logic [1:0]  cnt_reg;
	logic [1:0]  cnt_next;
	logic        push;
	logic        pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data  = mem_reg[rd_ptr_reg];

	always_comb begin
		cnt_next = cnt_reg + 2'(push) - 2'(pop);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg    <= 2'h0;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			in_ready   <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			in_ready <= (cnt_next != 2'h2);
			if (push)
				wr_ptr_reg <= !wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= !rd_ptr_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end
endmodule : jst_pair_buf

// >>> rtl/jst_tx_top.sv
// Purpose: transmit link layer for a two-channel converter: start-up, packing, substitution, scrambling
// Assumes: ref_clk is the sample clock; one octet per lane per cycle goes to the 8b/10b encoder
// Notes:   link settings are taken up only while the receiver holds sync asserted
`timescale 1ns/10ps
`include "jst_params.svh"

// Function
// - while sync is asserted every active lane sends comma characters.
// - on sync release commas stop and the alignment sequence begins.
// - alignment sequence is exactly four multiframes of K frames each.
// - second multiframe carries the full link parameter set.
// - alignment sequence carries start, end and parameter marker characters.
// - sample data follows directly after the alignment sequence.
// - repeated last frame octet is replaced with the frame-end character.
// - with lane sync enabled, repeated multiframe end uses the multiframe-end character.
// - self-synchronizing scrambler per lane, bypassable by configuration.
// - alignment sequence runs through the scrambler to seed it.
// - sync release is the fixed timing reference for the sequence.
// - efficient packing after reset; simple only after reprogramming.
// - simple packing pads samples to 16 bits, one sample per frame.
// - efficient packing concatenates samples and slices them into octets.
// - link may be downgraded to two lanes by configuration.
// - transport test patterns replace samples ahead of packing.
// - link test patterns bypass packing and feed the encoder directly.
// - test pattern selection and enable sit in register test_pattern_control.
// - link pseudo-random pattern is standard PRBS7.
// - transport test patterns restart when sync releases.
// - link parameters always at least one are stored minus one.
// - lane zero carries the frame start, then lane one, then lane two.
// - nap repeats the last valid sample so the link stays up.
module jst_tx_top (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        sync_n_pin,
	input  wire logic        nap_pin,
	input  wire logic [13:0] samp_ch0,
	input  wire logic [13:0] samp_ch1,
	input  wire logic        samp_valid,
	output logic             samp_ready,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [7:0]  cfg_wdata,
	output logic [7:0]       cfg_rdata,
	output logic [23:0]      lane_octet,
	output logic [2:0]       lane_ctrl
);
	// ==========================================================
	// helpers
	function automatic logic [22:0] jst_scr(input logic [14:0] s_in, input logic [7:0] d);
		logic [14:0] s;
		logic [7:0]  o;
		s = s_in;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			o[i] = d[i] ^ s[14] ^ s[13];
			s    = {s[13:0], o[i]};
		end
		return {s, o};
	endfunction : jst_scr

	function automatic logic [14:0] jst_prbs7(input logic [6:0] p_in);
		logic [6:0] p;
		logic [7:0] o;
		p = p_in;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			o[i] = p[6] ^ p[5];
			p    = {p[5:0], o[i]};
		end
		return {p, o};
	endfunction : jst_prbs7

	function automatic logic [7:0] jst_cfg_oct(input logic [3:0] idx, input logic [1:0] lane,
		input logic simple, input logic two, input logic scr, input logic [4:0] km1);
		logic [7:0] o [0:13];
		logic [7:0] sum;
		o[0]  = `JST_DEV_ID;
		o[1]  = `JST_BANK_ID;
		o[2]  = {6'h00, lane};
		o[3]  = {scr, 2'b00, two ? 5'h01 : 5'h02};
		o[4]  = {5'h00, simple ? `JST_F_SIM_M1 : `JST_F_EFF_M1};
		o[5]  = {3'h0, km1};
		o[6]  = `JST_M_M1;
		o[7]  = {3'h0, `JST_N_M1};
		o[8]  = {`JST_SUBCV, simple ? `JST_NP_SIM_M1 : `JST_N_M1};
		o[9]  = {`JST_JESDV, 2'b00, simple ? `JST_SS_M1 : (two ? `JST_S2_M1 : `JST_S3_M1)};
		o[10] = 8'h00;
		o[11] = 8'h00;
		o[12] = 8'h00;
		sum   = 8'h00;
		for (int i = 0; i < 13; i++)
			sum = sum + o[i];
		o[13] = sum;
		return o[idx];
	endfunction : jst_cfg_oct

	// ==========================================================
	// pin synchronisers and sync edge
	logic sync_m_reg, sync_s_reg, sync_d_reg, nap_m_reg, nap_s_reg, sync_rise;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_m_reg <= 1'b0;
			sync_s_reg <= 1'b0;
			sync_d_reg <= 1'b0;
			nap_m_reg  <= 1'b0;
			nap_s_reg  <= 1'b0;
		end else begin
			sync_m_reg <= sync_n_pin;
			sync_s_reg <= sync_m_reg;
			sync_d_reg <= sync_s_reg;
			nap_m_reg  <= nap_pin;
			nap_s_reg  <= nap_m_reg;
		end
	end
	assign sync_rise = sync_s_reg && !sync_d_reg;

	// ==========================================================
	// configuration registers
	logic [7:0] tpat_reg, link_reg;
	logic [4:0] km1_reg;
	logic       act_simple, act_two, act_scr, act_lsync, tpl, llp;
	logic [4:0] act_km1;
	jst_pkg::jst_state_t state_reg, state_next;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tpat_reg  <= `JST_TPAT_RST;
			link_reg  <= `JST_LINK_RST;
			km1_reg   <= `JST_KM1_RST;
			cfg_rdata <= 8'h00;
		end else begin
			if (cfg_wr) begin
				if (cfg_addr == `JST_ADDR_TPAT)
					tpat_reg <= cfg_wdata;
				else if (cfg_addr == `JST_ADDR_LINK)
					link_reg <= cfg_wdata;
				else if (cfg_addr == `JST_ADDR_KM1)
					km1_reg <= cfg_wdata[4:0];
			end
			if (cfg_rd) begin
				if (cfg_addr == `JST_ADDR_TPAT)
					cfg_rdata <= tpat_reg;
				else if (cfg_addr == `JST_ADDR_LINK)
					cfg_rdata <= link_reg;
				else if (cfg_addr == `JST_ADDR_KM1)
					cfg_rdata <= {3'h0, km1_reg};
				else if (cfg_addr == `JST_ADDR_STAT)
					cfg_rdata <= {4'h0, nap_s_reg, state_reg};
				else
					cfg_rdata <= 8'h00;
			end
		end
	end

	// settings are taken up only while sync is held asserted
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			act_simple <= 1'b0;
			act_two    <= 1'b0;
			act_scr    <= 1'b0;
			act_lsync  <= 1'b1;
			act_km1    <= `JST_KM1_RST;
		end else if (state_reg == jst_pkg::JST_CGS) begin
			act_simple <= link_reg[`JST_LINK_SIMPLE];
			act_two    <= link_reg[`JST_LINK_TWO] || link_reg[`JST_LINK_SIMPLE];
			act_scr    <= link_reg[`JST_LINK_SCR];
			act_lsync  <= link_reg[`JST_LINK_LSYNC];
			act_km1    <= km1_reg;
		end
	end

	assign tpl = tpat_reg[`JST_TPAT_EN] && (tpat_reg[2:0] == jst_pkg::JST_TP_RAMP ||
		tpat_reg[2:0] == jst_pkg::JST_TP_ALT);
	assign llp = tpat_reg[`JST_TPAT_EN] && (tpat_reg[2:0] == jst_pkg::JST_TP_PRBS ||
		tpat_reg[2:0] == jst_pkg::JST_TP_CONST);

	// ==========================================================
	// link state machine and frame counters
	logic [2:0] oct_reg, f_m1, s_m1;
	logic [4:0] frm_reg;
	logic [1:0] mf_reg;
	logic [7:0] mfpos_reg;
	logic       frame_end, mf_end, ila_done;

	assign f_m1      = act_simple ? `JST_F_SIM_M1 : `JST_F_EFF_M1;
	assign s_m1      = act_simple ? `JST_SS_M1 : (act_two ? `JST_S2_M1 : `JST_S3_M1);
	assign frame_end = (oct_reg == f_m1);
	assign mf_end    = frame_end && (frm_reg == act_km1);
	assign ila_done  = mf_end && (mf_reg == `JST_ILA_MF_LAST);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			jst_pkg::JST_CGS: begin
				if (sync_rise)
					state_next = jst_pkg::JST_ILA;
			end
			jst_pkg::JST_ILA: begin
				if (!sync_s_reg)
					state_next = jst_pkg::JST_CGS;
				else if (ila_done)
					state_next = jst_pkg::JST_DATA;
			end
			jst_pkg::JST_DATA: begin
				if (!sync_s_reg)
					state_next = jst_pkg::JST_CGS;
			end
			default: state_next = jst_pkg::JST_CGS;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			state_reg <= jst_pkg::JST_CGS;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			oct_reg   <= 3'h0;
			frm_reg   <= 5'h00;
			mf_reg    <= 2'h0;
			mfpos_reg <= 8'h00;
		end else if (state_reg == jst_pkg::JST_CGS) begin
			oct_reg   <= 3'h0;
			frm_reg   <= 5'h00;
			mf_reg    <= 2'h0;
			mfpos_reg <= 8'h00;
		end else if (frame_end) begin
			oct_reg   <= 3'h0;
			frm_reg   <= mf_end ? 5'h00 : frm_reg + 5'h01;
			mf_reg    <= mf_end ? mf_reg + 2'h1 : mf_reg;
			mfpos_reg <= mf_end ? 8'h00 : mfpos_reg + 8'h01;
		end else begin
			oct_reg   <= oct_reg + 3'h1;
			mfpos_reg <= mfpos_reg + 8'h01;
		end
	end

	// ==========================================================
	// sample gathering, test pattern sources and packing
	logic [27:0]  buf_data;
	logic         buf_valid, buf_take, gather;
	logic [2:0]   take_cnt;
	logic [13:0]  src0, src1, last0_reg, last1_reg, ramp_reg;
	logic         alt_reg;
	logic [83:0]  c0_sr, c1_sr;
	logic [167:0] frame_reg;
	logic [6:0]   prbs_reg;
	logic [14:0]  prbs_res;

	assign gather   = (state_reg != jst_pkg::JST_CGS) && (take_cnt <= s_m1);
	assign buf_take = gather && !tpl && !nap_s_reg;

	jst_pair_buf jst_pair_buf_i (
		.clk       (ref_clk),
		.reset_n   (reset_n),
		.in_valid  (samp_valid),
		.in_ready  (samp_ready),
		.in_data   ({samp_ch0, samp_ch1}),
		.out_valid (buf_valid),
		.out_ready (buf_take),
		.out_data  (buf_data)
	);

	always_comb begin
		src0 = last0_reg;
		src1 = last1_reg;
		if (tpl) begin
			src0 = (tpat_reg[2:0] == jst_pkg::JST_TP_RAMP) ? ramp_reg : (alt_reg ? `JST_ALT_B : `JST_ALT_A);
			src1 = (tpat_reg[2:0] == jst_pkg::JST_TP_RAMP) ? ~ramp_reg : (alt_reg ? `JST_ALT_A : `JST_ALT_B);
		end else if (!nap_s_reg && buf_valid) begin
			src0 = buf_data[27:14];
			src1 = buf_data[13:0];
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ramp_reg <= 14'h0000;
			alt_reg  <= 1'b0;
		end else if (sync_rise) begin
			ramp_reg <= 14'h0000;
			alt_reg  <= 1'b0;
		end else if (gather && tpl) begin
			ramp_reg <= ramp_reg + 14'h0001;
			alt_reg  <= !alt_reg;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			take_cnt  <= 3'h0;
			c0_sr     <= '0;
			c1_sr     <= '0;
			last0_reg <= 14'h0000;
			last1_reg <= 14'h0000;
			frame_reg <= '0;
		end else begin
			if (state_reg == jst_pkg::JST_CGS || frame_end)
				take_cnt <= 3'h0;
			else if (gather)
				take_cnt <= take_cnt + 3'h1;
			if (gather) begin
				c0_sr     <= {c0_sr[69:0], src0};
				c1_sr     <= {c1_sr[69:0], src1};
				last0_reg <= src0;
				last1_reg <= src1;
			end
			if (frame_end) begin
				if (act_simple)
					frame_reg <= {c0_sr[13:0], 2'b00, c1_sr[13:0], 2'b00, 136'h0};
				else if (act_two)
					frame_reg <= {c0_sr[55:0], c1_sr[55:0], 56'h0};
				else
					frame_reg <= {c0_sr, c1_sr};
			end
		end
	end

	assign prbs_res = jst_prbs7(prbs_reg);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			prbs_reg <= `JST_PRBS_SEED;
		else if (state_reg == jst_pkg::JST_DATA && llp)
			prbs_reg <= prbs_res[14:8];
	end

	// ==========================================================
	// per-lane octet path
	logic [7:0] oct_q [0:2];
	logic       ctl_q [0:2];

	for (genvar l = 0; l < 3; l++) begin : g_lane
		logic [14:0]  scr_reg, scr_next;
		logic [7:0]   prev_reg, prev_next, oct_next, scr_in, data_oct;
		logic         ctl_next;
		logic [22:0]  sres;
		logic [4:0]   sel;
		logic [167:0] shv;

		always_comb begin
			sel      = (act_simple ? 5'(2 * l) : 5'(7 * l)) + {2'b00, oct_reg};
			shv      = frame_reg << {sel, 3'b000};
			scr_in   = (state_reg == jst_pkg::JST_ILA) ? mfpos_reg : shv[167:160];
			if (state_reg == jst_pkg::JST_ILA && mf_reg == 2'h1 && mfpos_reg >= `JST_CFG_FIRST &&
				mfpos_reg <= `JST_CFG_LAST)
				scr_in = jst_cfg_oct(4'(mfpos_reg - `JST_CFG_FIRST), 2'(l), act_simple, act_two,
					act_scr, act_km1);
			sres      = jst_scr(scr_reg, scr_in);
			data_oct  = act_scr ? sres[7:0] : scr_in;
			scr_next  = scr_reg;
			prev_next = prev_reg;
			oct_next  = 8'h00;
			ctl_next  = 1'b0;
			case (state_reg)
				jst_pkg::JST_CGS: begin
					oct_next = `JST_K_COMMA;
					ctl_next = 1'b1;
				end
				jst_pkg::JST_ILA: begin
					ctl_next = 1'b1;
					if (mfpos_reg == 8'h00)
						oct_next = `JST_K_R;
					else if (mf_end)
						oct_next = `JST_K_A;
					else if (mf_reg == 2'h1 && mfpos_reg == 8'h01)
						oct_next = `JST_K_Q;
					else begin
						oct_next = scr_in;
						ctl_next = 1'b0;
						scr_next = sres[22:8];
					end
					if (frame_end)
						prev_next = oct_next;
				end
				jst_pkg::JST_DATA: begin
					if (llp) begin
						oct_next = (tpat_reg[2:0] == jst_pkg::JST_TP_PRBS) ? prbs_res[7:0] : `JST_D_CONST;
					end else begin
						oct_next = data_oct;
						scr_next = sres[22:8];
						if (frame_end) begin
							prev_next = data_oct;
							if (data_oct == prev_reg) begin
								ctl_next = 1'b1;
								oct_next = (mf_end && act_lsync) ? `JST_K_A : `JST_K_F;
							end
						end
					end
				end
				default: oct_next = 8'h00;
			endcase
			if (l == 2 && act_two) begin
				oct_next = 8'h00;
				ctl_next = 1'b0;
			end
		end

		always_ff @(posedge ref_clk or negedge reset_n) begin
			if (!reset_n) begin
				scr_reg  <= 15'h0000;
				prev_reg <= 8'h00;
				oct_q[l] <= 8'h00;
				ctl_q[l] <= 1'b0;
			end else begin
				scr_reg  <= scr_next;
				prev_reg <= prev_next;
				oct_q[l] <= oct_next;
				ctl_q[l] <= ctl_next;
			end
		end
	end

	assign lane_octet = {oct_q[2], oct_q[1], oct_q[0]};
	assign lane_ctrl  = {ctl_q[2], ctl_q[1], ctl_q[0]};

	// ==========================================================
	// checks
	logic [9:0] ila_len_reg, ila_exp;
	assign ila_exp = `JST_ILA_MF * (10'(act_km1) + 10'h001) * (10'(f_m1) + 10'h001);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			ila_len_reg <= 10'h000;
		else if (state_reg == jst_pkg::JST_ILA)
			ila_len_reg <= ila_len_reg + 10'h001;
		else
			ila_len_reg <= 10'h000;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	comma_while_sync_a: assert property ((state_reg == jst_pkg::JST_CGS) |=>
		(lane_octet[7:0] == `JST_K_COMMA) && lane_ctrl[0])
		else $error("comma missing while sync asserted");
	ila_on_release_a: assert property (sync_rise && state_reg == jst_pkg::JST_CGS |=>
		state_reg == jst_pkg::JST_ILA ##1 lane_octet[7:0] == `JST_K_R)
		else $error("alignment sequence did not start on sync release");
	ila_length_a: assert property ((state_reg == jst_pkg::JST_ILA && state_next == jst_pkg::JST_DATA) |->
		ila_len_reg == ila_exp - 10'h001)
		else $error("alignment sequence length wrong");
	q_marker_a: assert property ((state_reg == jst_pkg::JST_ILA && mf_reg == 2'h1 && mfpos_reg == 8'h01) |=>
		lane_octet[7:0] == `JST_K_Q && lane_ctrl[0])
		else $error("parameter marker missing");
	mf_end_marker_a: assert property ((state_reg == jst_pkg::JST_ILA && mf_end) |=>
		lane_octet[7:0] == `JST_K_A && lane_ctrl[0])
		else $error("multiframe end marker missing");
	data_follows_a: assert property ((state_reg == jst_pkg::JST_ILA && ila_done && sync_s_reg) |=>
		state_reg == jst_pkg::JST_DATA)
		else $error("data did not follow alignment sequence");
	frame_subst_a: assert property ((state_reg == jst_pkg::JST_DATA && !llp && frame_end && !mf_end &&
		g_lane[0].data_oct == g_lane[0].prev_reg) |=> lane_octet[7:0] == `JST_K_F && lane_ctrl[0])
		else $error("frame end substitution missing");
	tpl_restart_a: assert property (sync_rise |=> ramp_reg == 14'h0000 && !alt_reg)
		else $error("transport pattern did not restart");
	lanes_idle_two_a: assert property (act_two && !$changed(act_two) |=>
		lane_octet[23:16] == 8'h00 && !lane_ctrl[2])
		else $error("third lane active in two-lane mode");
endmodule : jst_tx_top

// >>> test/jst_rx_model.sv
// Purpose: receiver side model that drives link sync
// Assumes: lane0 comma is BC with its control flag set
// Notes:   sync stays asserted while hold is high
`timescale 1ns/10ps
module jst_rx_model (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        hold,
	input  wire logic [23:0] lane_octet,
	input  wire logic [2:0]  lane_ctrl,
	output logic             sync_n_pin
);
	int n_comma;
	// =====
	// count commas, release sync once aligned; the pin moves just after a rising edge so its latency is fixed
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			n_comma    <= 0;
			sync_n_pin <= 1'b0;
		end else begin
			if (lane_octet[7:0] === 8'hBC && lane_ctrl[0] === 1'b1)
				n_comma <= n_comma + 1;
			else
				n_comma <= 0;
			sync_n_pin <= hold ? 1'b0 : (sync_n_pin | (n_comma >= 8));
		end
	end
endmodule : jst_rx_model

// >>> test/jesd204_serial_transmitter_tb.sv
// Purpose: self-checking bench for the serial transmitter
// Assumes: receiver model releases sync after eight commas
// Notes:   inputs change on the falling edge
`timescale 1ns/10ps
`include "jst_params.svh"
module jesd204_serial_transmitter_tb;
	logic        ref_clk, reset_n, sync_n_pin, nap_pin, hold;
	logic [13:0] samp_ch0, samp_ch1;
	logic        samp_valid, samp_ready, cfg_wr, cfg_rd;
	logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
	logic [23:0] lane_octet;
	logic [2:0]  lane_ctrl;
	logic [7:0]  ila [0:251];
	int          n_mismatch, cmp_count, n1, n2;

	jst_tx_top jst_tx_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .sync_n_pin(sync_n_pin),
		.nap_pin(nap_pin), .samp_ch0(samp_ch0), .samp_ch1(samp_ch1), .samp_valid(samp_valid),
		.samp_ready(samp_ready), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .lane_octet(lane_octet), .lane_ctrl(lane_ctrl));
	jst_rx_model jst_rx_model_i (.ref_clk(ref_clk), .reset_n(reset_n), .hold(hold),
		.lane_octet(lane_octet), .lane_ctrl(lane_ctrl), .sync_n_pin(sync_n_pin));

	// =====
	// shared tasks
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		cfg_wr    = 1'b1;
		cfg_addr  = a;
		cfg_wdata = d;
		@(negedge ref_clk);
		cfg_wr = 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		cfg_rd   = 1'b1;
		cfg_addr = a;
		@(negedge ref_clk);
		cfg_rd = 1'b0;
		chk(cfg_rdata, e);
	endtask : rdc
	task automatic wait_ila(output int n);
		n = 0;
		while (!(lane_octet[7:0] === `JST_K_R && lane_ctrl[0] === 1'b1)) begin
			@(negedge ref_clk);
			n++;
			if (n > 300) begin
				n_mismatch++;
				tally_and_finish();
			end
		end
	endtask : wait_ila

	// =====
	// scenarios
	task automatic t_regs();
		rdc(`JST_ADDR_TPAT, `JST_TPAT_RST);
		rdc(`JST_ADDR_LINK, `JST_LINK_RST);
		rdc(`JST_ADDR_KM1, {3'h0, `JST_KM1_RST});
		rdc(`JST_ADDR_STAT, 8'h01);
		wr(8'h55, 8'hFF);
		rdc(8'h55, 8'h00);
		wr(`JST_ADDR_TPAT, 8'h81);
		rdc(`JST_ADDR_TPAT, 8'h81);
		wr(`JST_ADDR_TPAT, `JST_TPAT_RST);
	endtask : t_regs
	task automatic t_comma();
		chk(lane_octet, {3{`JST_K_COMMA}});
		chk(lane_ctrl, 3'h7);
		chk(samp_ready, 1'b0);
	endtask : t_comma
	task automatic t_bringup();
		int i;
		hold = 1'b0;
		wait_ila(n1);
		for (i = 0; i < 252; i++) begin
			ila[i] = lane_octet[7:0];
			@(negedge ref_clk);
		end
		chk(n1, 5);
		chk(ila[0], `JST_K_R);
		chk(ila[62], `JST_K_A);
		chk(ila[64], `JST_K_Q);
		chk(ila[65], `JST_DEV_ID);
		chk(ila[251], `JST_K_A);
		rdc(`JST_ADDR_STAT, 8'h04);
	endtask : t_bringup
	task automatic t_subst();
		int i, nf, na, nr;
		nf = 0;
		na = 0;
		nr = 0;
		repeat (63) @(negedge ref_clk);
		for (i = 0; i < 63; i++) begin
			if (lane_ctrl[0] === 1'b1 && lane_octet[7:0] === `JST_K_F)
				nf++;
			if (lane_ctrl[0] === 1'b1 && lane_octet[7:0] === `JST_K_A)
				na++;
			if (samp_ready === 1'b1)
				nr++;
			@(negedge ref_clk);
		end
		chk(nf, 8);
		chk(na, 1);
		chk(nr > 0, 1'b1);
	endtask : t_subst
	task automatic t_link();
		logic [23:0] s;
		int          i;
		s = 24'h00_0000;
		wr(`JST_ADDR_TPAT, 8'h84);
		repeat (6) @(negedge ref_clk);
		for (i = 0; i < 3; i++) begin
			s = {s[15:0], lane_octet[7:0]};
			chk(lane_ctrl[0], 1'b0);
			@(negedge ref_clk);
		end
		for (i = 0; i < 17; i++)
			chk(s[i], s[i+6] ^ s[i+7]);
		wr(`JST_ADDR_TPAT, 8'h85);
		repeat (6) @(negedge ref_clk);
		chk(lane_octet, {3{`JST_D_CONST}});
		wr(`JST_ADDR_TPAT, `JST_TPAT_RST);
	endtask : t_link
	task automatic t_resync();
		wr(`JST_ADDR_LINK, 8'h0A);
		repeat (3) @(negedge ref_clk);
		chk(lane_octet[23:16] !== 8'h00, 1'b1);
		hold = 1'b1;
		repeat (16) @(negedge ref_clk);
		chk(lane_ctrl, 3'h3);
		chk(lane_octet[23:16], 8'h00);
		chk(lane_octet[7:0], `JST_K_COMMA);
		hold = 1'b0;
		wait_ila(n2);
		chk(n2, n1);
	endtask : t_resync
	task automatic t_nap();
		int i;
		repeat (260) @(negedge ref_clk);
		wr(`JST_ADDR_TPAT, 8'h81);
		repeat (20) @(negedge ref_clk);
		// ramp on channel 0, inverted ramp on channel 1: lane 1 mirrors lane 0 inverted in two-lane packing
		for (i = 0; i < 14; i++) begin
			chk({16'h0000, lane_octet[15:8]}, {16'h0000, ~lane_octet[7:0]});
			@(negedge ref_clk);
		end
		wr(`JST_ADDR_TPAT, `JST_TPAT_RST);
		nap_pin = 1'b1;
		repeat (5) @(negedge ref_clk);
		rdc(`JST_ADDR_STAT, 8'h0C);
		chk(lane_ctrl[2], 1'b0);
	endtask : t_nap

	// =====
	// clock, reset and sequence
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		reset_n    = 1'b0;
		nap_pin    = 1'b0;
		hold       = 1'b1;
		samp_ch0   = 14'h1234;
		samp_ch1   = 14'h0ABC;
		samp_valid = 1'b1;
		cfg_wr     = 1'b0;
		cfg_rd     = 1'b0;
		cfg_addr   = 8'h00;
		cfg_wdata  = 8'h00;
		n_mismatch = 0;
		cmp_count  = 0;
		repeat (10) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		t_regs();
		t_comma();
		t_bringup();
		t_subst();
		t_link();
		t_resync();
		t_nap();
		tally_and_finish();
	end
endmodule : jesd204_serial_transmitter_tb
